//--- hw/thermal_monitor_control.sv
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Catastrophic trip always armed; halts execution until reset completes.
// - Misc-enable bit 3 enables automatic thermal control; cleared by reset.
// - Capability report shows duty-cycle at bit 29, freq/voltage at bit 8.
// - Early parts: bit 16 plus bit 3 picks freq/voltage; else duty-cycle.
// - Later parts: misc-enable bit 13 enables freq/voltage thermal control.
// - Freq/voltage trip moves to operating point in mode-control bits 15:0.
// - Duty-cycle control gates the core clock internally; external pin unused.
// - Freq/voltage control uses the same trip sensor, lowering point instead.
// - Under duty-cycle control a performance write may start transition at once.
// - Under freq/voltage control a performance write waits until disengage.
// - Status bit 0 shows a live trip while engaged; writes to it are ignored.
// - Status bit 1 sticky on trip; cleared by software or reset.
// - Engaged at least about 1 ms, then until sensor drops with hysteresis.
// - Interrupts to the core are held pending during stop-clock intervals.
// - High-enable bit 0 raises interrupt on each upward crossing.
// - Low-enable bit 1 raises interrupt on each downward crossing.
// - Reset clears both interrupt enables and masks the vector entry.
// - Throttling never alters the time-stamp counter increment rate.
// - Adaptive control picks a target point by whether cooling worked.
// - Each core trips independently; adaptive trip moves every core down.
module thermal_monitor_control
  import thermal_pkg::*;
#(
  parameter int MIN_ENGAGE = MIN_ENGAGE_CYC,
  parameter bit EARLY_PART = 1'b0,
  parameter int NUM_CORES = 2
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_CORES-1:0] trip_hot,
  input wire logic [NUM_CORES-1:0] trip_cool,
  input wire logic catastrophic_trip,
  input wire logic core_irq,
  input wire logic vector_ack,
  output logic vector_req,
  output logic core_irq_out,
  output logic exec_halt,
  output logic core_clk_enable,
  output logic [15:0] op_point,
  output logic op_point_change,
  output logic [NUM_CORES-1:0] core_low_point,
  output logic [63:0] tsc
);

  initial begin
    if (NUM_CORES < 1 || NUM_CORES > 8 || MIN_ENGAGE < 1 || MIN_ENGAGE > (1 << 24)) begin
      $error("thermal_monitor_control: unsupported parameter");
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] misc_q;
  logic [31:0] mode_q;
  logic [1:0] int_en_q;
  logic log_q;
  logic vec_mask_q;
  logic adapt_en_q;
  logic [15:0] perf_target_q;
  logic perf_pending_q;
  logic halt_q;
  logic [1:0] cool_score_q;
  therm_state_t state_q;
  logic [23:0] hold_cnt_q;
  logic engaged_prev_q;
  logic irq_pend_q;
  logic vreq_q;

  logic any_hot;
  logic all_cool;
  logic tm_enabled;
  logic fv_mode;
  logic engaged;
  logic duty_active;
  logic up_cross;
  logic down_cross;
  logic [31:0] status_word;

  function automatic logic is_write(input logic [3:0] addr, input logic [3:0] target,
                                    input logic wr);
    is_write = wr && (addr == target);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      misc_q <= MISC_RESET;
    end else if (is_write(reg_addr, ADDR_MISC_ENABLE, reg_wr)) begin
      misc_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_q <= MODE_RESET;
    end else if (is_write(reg_addr, ADDR_MODE_CTRL, reg_wr)) begin
      mode_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_en_q <= INT_EN_RESET;
      vec_mask_q <= 1'b1;
    end else if (is_write(reg_addr, ADDR_INT_EN, reg_wr)) begin
      int_en_q <= {reg_wdata[INT_LOW_BIT], reg_wdata[INT_HIGH_BIT]};
      vec_mask_q <= reg_wdata[31];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      adapt_en_q <= 1'b0;
    end else if (is_write(reg_addr, ADDR_ADAPT_CTRL, reg_wr)) begin
      adapt_en_q <= reg_wdata[ADAPT_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Mode selection and trip engagement
  // ----------------------------------------------------------------
  assign any_hot = |trip_hot;
  assign all_cool = &trip_cool;
  assign tm_enabled = misc_q[MISC_TM_EN_BIT] || (!EARLY_PART && misc_q[MISC_FV_EN_BIT]);
  assign fv_mode = EARLY_PART ? (misc_q[MISC_TM_EN_BIT] && mode_q[MODE_SELECT_BIT])
                              : misc_q[MISC_FV_EN_BIT];

  // The engaged state counts the minimum engaged time, then the hold state waits
  // for the hysteresis-qualified cool indication from every core.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= TH_IDLE;
      hold_cnt_q <= 24'h000000;
    end else begin
      case (state_q)
        TH_IDLE: begin
          hold_cnt_q <= 24'h000000;
          if (tm_enabled && any_hot) begin
            state_q <= TH_ENGAGED;
          end
        end
        TH_ENGAGED: begin
          if (hold_cnt_q >= 24'(MIN_ENGAGE - 1)) begin
            state_q <= TH_HOLD;
          end else begin
            hold_cnt_q <= hold_cnt_q + 24'h000001;
          end
        end
        TH_HOLD: begin
          if (!any_hot && all_cool) begin
            state_q <= TH_IDLE;
          end
        end
        default: begin
          state_q <= TH_IDLE;
        end
      endcase
    end
  end

  assign engaged = (state_q != TH_IDLE);
  assign duty_active = engaged && !fv_mode;

  duty_gate u_duty_gate (
    .clk_sys(clk_sys),
    .srst(srst),
    .active(duty_active),
    .clk_enable(core_clk_enable)
  );

  // ----------------------------------------------------------------
  // Catastrophic trip
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      halt_q <= 1'b0;
    end else if (catastrophic_trip) begin
      halt_q <= 1'b1;
    end
  end

  assign exec_halt = halt_q;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // A trip in the same cycle as a software clear keeps the log set.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      log_q <= 1'b0;
    end else if (any_hot) begin
      log_q <= 1'b1;
    end else if (is_write(reg_addr, ADDR_STATUS, reg_wr) && !reg_wdata[STAT_LOG_BIT]) begin
      log_q <= 1'b0;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_LIVE_BIT] = engaged && any_hot;
    status_word[STAT_LOG_BIT] = log_q;
  end

  // ----------------------------------------------------------------
  // Operating point and performance requests
  // ----------------------------------------------------------------
  // Adaptive score: rises while hot persists in hold, falls when cooling works.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cool_score_q <= 2'h0;
    end else if (adapt_en_q && state_q == TH_HOLD && hold_cnt_q == 24'(MIN_ENGAGE - 1)) begin
      if (any_hot && cool_score_q != 2'h3) begin
        cool_score_q <= cool_score_q + 2'h1;
      end else if (!any_hot && cool_score_q != 2'h0) begin
        cool_score_q <= cool_score_q - 2'h1;
      end
    end
  end

  logic [15:0] op_point_q;
  logic change_q;
  logic [15:0] thermal_target;
  logic fv_engaged;

  assign fv_engaged = engaged && fv_mode;
  // Each adaptive step drops the target by one step of the low byte.
  assign thermal_target = adapt_en_q ? (mode_q[15:0] - {14'h0000, cool_score_q})
                                     : mode_q[15:0];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      perf_target_q <= 16'h0000;
      perf_pending_q <= 1'b0;
    end else if (is_write(reg_addr, ADDR_PERF_CTRL, reg_wr)) begin
      perf_target_q <= reg_wdata[15:0];
      perf_pending_q <= 1'b1;
    end else if (perf_pending_q && !fv_engaged) begin
      perf_pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      op_point_q <= 16'h0000;
      change_q <= 1'b0;
    end else if (fv_engaged && op_point_q != thermal_target) begin
      op_point_q <= thermal_target;
      change_q <= 1'b1;
    end else if (perf_pending_q && !fv_engaged) begin
      op_point_q <= perf_target_q;
      change_q <= 1'b1;
    end else begin
      change_q <= 1'b0;
    end
  end

  assign op_point = op_point_q;
  assign op_point_change = change_q;

  // Adaptive: any core's trip lowers every core; otherwise only the hot core.
  logic [NUM_CORES-1:0] low_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      low_q <= '0;
    end else if (!fv_engaged) begin
      low_q <= '0;
    end else if (adapt_en_q) begin
      low_q <= '1;
    end else begin
      low_q <= low_q | trip_hot;
    end
  end
  assign core_low_point = low_q;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      engaged_prev_q <= 1'b0;
    end else begin
      engaged_prev_q <= any_hot;
    end
  end

  assign up_cross = any_hot && !engaged_prev_q && int_en_q[INT_HIGH_BIT];
  assign down_cross = !any_hot && engaged_prev_q && int_en_q[INT_LOW_BIT];

  // A new crossing in the acknowledge cycle keeps the request raised.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vreq_q <= 1'b0;
    end else if ((up_cross || down_cross) && !vec_mask_q) begin
      vreq_q <= 1'b1;
    end else if (vector_ack) begin
      vreq_q <= 1'b0;
    end
  end
  assign vector_req = vreq_q;

  // Interrupts arriving while the clock is stopped wait for the clock.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_pend_q <= 1'b0;
    end else if (core_irq) begin
      irq_pend_q <= 1'b1;
    end else if (core_clk_enable) begin
      irq_pend_q <= 1'b0;
    end
  end
  assign core_irq_out = core_clk_enable && (irq_pend_q || core_irq);

  // ----------------------------------------------------------------
  // Time-stamp counter, unaffected by throttling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tsc <= 64'h0;
    end else begin
      tsc <= tsc + 64'h1;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_MISC_ENABLE) begin
        reg_rdata <= misc_q;
      end else if (reg_addr == ADDR_MODE_CTRL) begin
        reg_rdata <= mode_q;
      end else if (reg_addr == ADDR_STATUS) begin
        reg_rdata <= status_word;
      end else if (reg_addr == ADDR_INT_EN) begin
        reg_rdata <= {vec_mask_q, 29'h0, int_en_q};
      end else if (reg_addr == ADDR_PERF_CTRL) begin
        reg_rdata <= {15'h0, perf_pending_q, perf_target_q};
      end else if (reg_addr == ADDR_CAPS) begin
        reg_rdata <= (32'h1 << CAP_DUTY_BIT) | (32'h1 << CAP_FV_BIT);
      end else if (reg_addr == ADDR_OP_POINT) begin
        reg_rdata <= {16'h0, op_point_q};
      end else if (reg_addr == ADDR_ADAPT_CTRL) begin
        reg_rdata <= {30'h0, cool_score_q[0], adapt_en_q};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

//--- pkg/thermal_pkg.sv
package thermal_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_MISC_ENABLE = 4'h0;
  localparam logic [3:0] ADDR_MODE_CTRL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_INT_EN = 4'h3;
  localparam logic [3:0] ADDR_PERF_CTRL = 4'h4;
  localparam logic [3:0] ADDR_CAPS = 4'h5;
  localparam logic [3:0] ADDR_OP_POINT = 4'h6;
  localparam logic [3:0] ADDR_ADAPT_CTRL = 4'h7;

  // Field positions.
  localparam int MISC_TM_EN_BIT = 3;
  localparam int MISC_FV_EN_BIT = 13;
  localparam int MODE_SELECT_BIT = 16;
  localparam int STAT_LIVE_BIT = 0;
  localparam int STAT_LOG_BIT = 1;
  localparam int INT_HIGH_BIT = 0;
  localparam int INT_LOW_BIT = 1;
  localparam int CAP_DUTY_BIT = 29;
  localparam int CAP_FV_BIT = 8;
  localparam int ADAPT_EN_BIT = 0;

  // Reset values.
  localparam logic [31:0] MISC_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [1:0] INT_EN_RESET = 2'h0;

  // Timing: minimum engaged time after a trip.
  localparam int CLK_HZ = 10_000_000;
  localparam int MIN_ENGAGE_US = 1000;
  localparam int MIN_ENGAGE_CYC = (MIN_ENGAGE_US * (CLK_HZ / 1_000_000));

  // Duty-cycle modulation period and clock-on share, in cycles.
  localparam int DUTY_PERIOD_CYC = 8;
  localparam int DUTY_ON_CYC = 4;

  typedef enum logic [1:0] {
    TH_IDLE,
    TH_ENGAGED,
    TH_HOLD
  } therm_state_t;

endpackage

//--- hw/duty_gate.sv
`timescale 1ns/10ps
module duty_gate
  import thermal_pkg::*;
#(
  parameter int PERIOD = DUTY_PERIOD_CYC,
  parameter int ON_CYC = DUTY_ON_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic active,
  output logic clk_enable
);

  initial begin
    if (PERIOD < 2 || PERIOD > 256 || ON_CYC < 1 || ON_CYC >= PERIOD) begin
      $error("duty_gate: bad period or on count");
    end
  end

  logic [7:0] phase_q;

  always_ff @(posedge clk_sys) begin
    if (srst || !active || phase_q == 8'(PERIOD - 1)) begin
      phase_q <= 8'h00;
    end else begin
      phase_q <= phase_q + 8'h01;
    end
  end

  // The core clock runs during the first ON_CYC cycles of each period.
  assign clk_enable = !active || (phase_q < 8'(ON_CYC));

endmodule

//--- bench/thermal_monitor_control_props.sv
`timescale 1ns/10ps
module thermal_monitor_control_props #(
  parameter int NUM_CORES = 2
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NUM_CORES-1:0] trip_hot,
  input wire logic catastrophic_trip,
  input wire logic vector_ack,
  input wire logic vector_req,
  input wire logic core_irq_out,
  input wire logic core_irq,
  input wire logic exec_halt,
  input wire logic core_clk_enable,
  input wire logic [63:0] tsc
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  halt_held_a: assert property (exec_halt |=> exec_halt)
    else $error("halt released without reset");
  halt_trip_a: assert property (catastrophic_trip |-> ##[1:2] exec_halt)
    else $error("catastrophic trip did not halt");
  tsc_rate_a: assert property ($past(srst) == 1'b0 |-> tsc == $past(tsc) + 64'h1)
    else $error("timestamp rate changed");
  irq_block_a: assert property (!core_clk_enable |-> !core_irq_out)
    else $error("interrupt delivered while clock stopped");
  irq_keep_a: assert property (core_irq && !core_clk_enable |-> ##[1:8] core_irq_out)
    else $error("held interrupt never delivered");
  vec_hold_a: assert property (vector_req && !vector_ack |=> vector_req)
    else $error("vector request dropped before ack");
  vec_drop_a: assert property ($fell(vector_req) |-> $past(vector_ack))
    else $error("vector request fell without ack");
  vec_cause_a: assert property ($rose(vector_req) |-> $past(|trip_hot) != $past(|trip_hot, 2))
    else $error("vector request without crossing");
  rdata_idle_a: assert property ($past(reg_rd) == 1'b0 |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule

//--- bench/vector_ctrl_model.sv
`timescale 1ns/10ps
module vector_ctrl_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic vector_req,
  input wire logic slow,
  output logic vector_ack
);
  // Acknowledges a held request at once or after three cycles, one cycle long.
  int wait_q;
  always @(posedge clk_sys) begin
    vector_ack <= 1'b0;
    if (srst || !vector_req || vector_ack) begin
      wait_q <= 0;
    end else if (wait_q >= (slow ? 3 : 0)) begin
      vector_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 1;
    end
  end
endmodule

//--- bench/tb_thermal_monitor_control.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_thermal_monitor_control;
  import thermal_pkg::*;
  localparam int MIN_ENG = 12;
  logic clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic catastrophic_trip = 1'b0, core_irq = 1'b0, seen;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic [1:0] trip_hot = 2'h0, trip_cool = 2'h3, core_low_point;
  logic vector_ack, vector_req, core_irq_out, exec_halt, core_clk_enable, op_point_change;
  logic [15:0] op_point;
  logic [63:0] tsc;
  int err_count = 0, comparisons = 0, cyc = 0, n, m, k;
  logic clk_en_early;
  logic [15:0] op_early;
  always #50 clk_sys = ~clk_sys;

  thermal_monitor_control #(.MIN_ENGAGE(MIN_ENG), .EARLY_PART(1'b0), .NUM_CORES(2)) i_dut (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trip_hot(trip_hot),
    .trip_cool(trip_cool), .catastrophic_trip(catastrophic_trip), .core_irq(core_irq),
    .vector_ack(vector_ack), .vector_req(vector_req), .core_irq_out(core_irq_out),
    .exec_halt(exec_halt), .core_clk_enable(core_clk_enable), .op_point(op_point),
    .op_point_change(op_point_change), .core_low_point(core_low_point), .tsc(tsc));
  vector_ctrl_model i_vec (.clk_sys(clk_sys), .srst(srst), .vector_req(vector_req),
    .slow(slow), .vector_ack(vector_ack));
  thermal_monitor_control #(.MIN_ENGAGE(MIN_ENG), .EARLY_PART(1'b1), .NUM_CORES(2)) i_dut_early (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .trip_hot(trip_hot),
    .trip_cool(trip_cool), .catastrophic_trip(catastrophic_trip), .core_irq(core_irq),
    .vector_ack(vector_ack), .vector_req(), .core_irq_out(), .exec_halt(),
    .core_clk_enable(clk_en_early), .op_point(op_early), .op_point_change(),
    .core_low_point(), .tsc());

  // ----------------------------------------
  // Bus and wait tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic wait_req(input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clk_sys);
      #1 seen = seen | vector_req;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(ADDR_MISC_ENABLE); `CHK(rv, 32'h0)
    rd(ADDR_STATUS); `CHK(rv[1:0], 2'b00)
    rd(ADDR_INT_EN); `CHK(rv, 32'h8000_0000)
    wr(ADDR_CAPS, 32'h0);
    rd(ADDR_CAPS); `CHK({rv[CAP_DUTY_BIT], rv[CAP_FV_BIT]}, 2'b11)
    rd(4'hF); `CHK(rv, 32'h0)
    $display("test reset done");
  endtask
  task automatic t_duty;
    wr(ADDR_INT_EN, 32'h1);
    wr(ADDR_MISC_ENABLE, 32'h8);
    @(posedge clk_sys);
    trip_hot <= 2'b01;
    trip_cool <= 2'b00;
    core_irq <= 1'b1;
    wait_req(4); `CHK(seen, 1'b1)
    rd(ADDR_STATUS); `CHK(rv[1:0], 2'b11)
    n = 0;
    m = 0;
    k = 0;
    repeat (2 * DUTY_PERIOD_CYC) begin
      @(posedge clk_sys);
      #1 n += !core_clk_enable;
      m += core_irq_out;
      k += !clk_en_early;
    end
    `CHK(n, 2 * (DUTY_PERIOD_CYC - DUTY_ON_CYC))
    `CHK(m, 2 * DUTY_ON_CYC)
    `CHK(k, 2 * (DUTY_PERIOD_CYC - DUTY_ON_CYC))
    wr(ADDR_PERF_CTRL, 32'h0042);
    @(posedge clk_sys);
    #1 `CHK(op_point_change, 1'b1)
    repeat (2) @(posedge clk_sys);
    #1 `CHK(op_point, 16'h0042)
    `CHK(op_point_change, 1'b0)
    @(posedge clk_sys);
    trip_hot <= 2'b00;
    trip_cool <= 2'b11;
    core_irq <= 1'b0;
    wait_req(MIN_ENG + 4); `CHK(seen, 1'b0)
    rd(ADDR_STATUS); `CHK(rv[1:0], 2'b10)
    wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS); `CHK(rv[1:0], 2'b00)
    $display("test duty done");
  endtask
  task automatic t_fv;
    wr(ADDR_INT_EN, 32'h2);
    wr(ADDR_MISC_ENABLE, 32'h2008);
    wr(ADDR_ADAPT_CTRL, 32'h1);
    wr(ADDR_MODE_CTRL, 32'h0001_0123);
    @(posedge clk_sys);
    trip_hot <= 2'b10;
    trip_cool <= 2'b00;
    slow <= 1'b1;
    wait_req(3); `CHK(seen, 1'b0)
    `CHK(op_point, 16'h0123)
    `CHK(op_early, 16'h0123)
    `CHK(core_low_point, 2'b11)
    `CHK(core_clk_enable, 1'b1)
    wr(ADDR_PERF_CTRL, 32'h0456);
    rd(ADDR_PERF_CTRL); `CHK(rv[16], 1'b1)
    `CHK(op_point, 16'h0123)
    @(posedge clk_sys);
    trip_hot <= 2'b00;
    trip_cool <= 2'b11;
    rd(ADDR_PERF_CTRL); `CHK(rv[16], 1'b1)
    wait_req(MIN_ENG + 8); `CHK(seen, 1'b1)
    `CHK(op_point, 16'h0456)
    // A trip that outlasts the minimum time walks the adaptive target down.
    @(posedge clk_sys);
    trip_hot <= 2'b01;
    trip_cool <= 2'b00;
    repeat (MIN_ENG + 6) @(posedge clk_sys);
    #1 `CHK(op_point, 16'h0120)
    @(posedge clk_sys);
    trip_hot <= 2'b00;
    trip_cool <= 2'b11;
    repeat (8) @(posedge clk_sys);
    $display("test freq done");
  endtask
  task automatic t_halt;
    @(posedge clk_sys);
    catastrophic_trip <= 1'b1;
    @(posedge clk_sys);
    catastrophic_trip <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 `CHK(exec_halt, 1'b1)
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1 `CHK(exec_halt, 1'b0)
    rd(ADDR_INT_EN); `CHK(rv, 32'h8000_0000)
    rd(ADDR_MISC_ENABLE); `CHK(rv[MISC_TM_EN_BIT], 1'b0)
    $display("test halt done");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_duty();
    t_fv();
    t_halt();
    results();
  end
endmodule

bind thermal_monitor_control thermal_monitor_control_props #(.NUM_CORES(NUM_CORES)) i_props (
  .clk_sys(clk_sys), .srst(srst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .trip_hot(trip_hot), .catastrophic_trip(catastrophic_trip), .vector_ack(vector_ack),
  .vector_req(vector_req), .core_irq_out(core_irq_out), .core_irq(core_irq),
  .exec_halt(exec_halt),
  .core_clk_enable(core_clk_enable), .tsc(tsc));
